//--- hw/core_sfr.v
/*
 * Core special register block: status flags, two indirect pointers with their
 * windows, bank select, accumulator and program counter high holding latch.
 * Assumes the execution datapath drives requests synchronous to SYS_CLK, waits
 * for SFR_RVALID while SFR_BUSY is high, and that RST_N is the power-on or
 * brown-out reset while OTHER_RST marks every other reset.
 */
`timescale 1ns/100ps
`default_nettype none
`include "core_sfr_map.vh"

module core_sfr #(
	parameter DATA_W = 8,
	parameter PTR_W  = 16,
	parameter BANK_W = 6,
	parameter PCH_W  = 7,
	parameter OFS_W  = 7,
	parameter PROG_W = 14
) (
	// Clock and resets.
	input  wire                      SYS_CLK,
	input  wire                      RST_N,
	input  wire                      OTHER_RST,
	// Register access port.
	input  wire [OFS_W-1:0]          SFR_ADDR,
	input  wire                      SFR_RD,
	input  wire                      SFR_WR,
	input  wire [DATA_W-1:0]         SFR_WDATA,
	output reg  [DATA_W-1:0]         SFR_RDATA,
	output reg                       SFR_RVALID,
	output reg                       SFR_BUSY,
	// Data and program memory behind the windows.
	output reg  [PTR_W-1:0]          MEM_ADDR,
	output reg                       MEM_RD,
	output reg                       MEM_WR,
	output reg                       MEM_PROG,
	output reg  [DATA_W-1:0]         MEM_WDATA,
	input  wire [DATA_W-1:0]         MEM_RDATA,
	input  wire [PROG_W-1:0]         PROG_RDATA,
	// Operation port.
	input  wire                      OP_VALID,
	input  wire [3:0]                OP_CODE,
	input  wire [DATA_W-1:0]         OP_OPERAND,
	input  wire                      OP_TO_ACC,
	output reg  [DATA_W-1:0]         OP_RESULT,
	output reg                       OP_DONE,
	// Power and watchdog events.
	input  wire                      SLEEP_EXEC,
	input  wire                      WATCHDOG_CLEAR_OP_EXEC,
	input  wire                      WDT_TIMEOUT,
	// Direct addressing and program counter.
	input  wire [OFS_W-1:0]          DIRECT_OFFSET,
	output reg  [BANK_W+OFS_W-1:0]   DATA_ADDR,
	input  wire [DATA_W-1:0]         PC_LOW,
	output reg                       PCL_WR,
	output reg  [DATA_W-1:0]         PCL_WDATA,
	output reg  [PCH_W-1:0]          PC_HIGH_LATCH,
	// Register views.
	output reg  [DATA_W-1:0]         ACC_Q,
	output reg  [DATA_W-1:0]         STATUS_Q,
	output reg  [PTR_W-1:0]          PTR0_Q,
	output reg  [PTR_W-1:0]          PTR1_Q,
	output reg  [BANK_W-1:0]         BANK_Q
);

	//****************************************************************
	// Register state.
	//****************************************************************
	reg [PTR_W-1:0]  ptr0_ff;
	reg [PTR_W-1:0]  ptr1_ff;
	reg [BANK_W-1:0] bank_ff;
	reg [DATA_W-1:0] acc_ff;
	reg [PCH_W-1:0]  pch_ff;
	reg              timeout_ff;
	reg              pwrdn_ff;
	reg              zero_ff;
	reg              nibc_ff;
	reg              carry_ff;
	reg              pend_ff;
	reg              prog_ff;

	wire [DATA_W-1:0] alu_result;
	wire              alu_zero;
	wire              alu_nib;
	wire              alu_carry;
	wire              upd_zero;
	wire              upd_nib;
	wire              upd_carry;

	//****************************************************************
	// Arithmetic unit.
	//****************************************************************
	core_alu_flags #(
		.W         (DATA_W)
	) u_alu (
		.op        (OP_CODE),
		.acc       (acc_ff),
		.opnd      (OP_OPERAND),
		.carry_in  (carry_ff),
		.result    (alu_result),
		.zero      (alu_zero),
		.nib_carry (alu_nib),
		.carry     (alu_carry),
		.upd_zero  (upd_zero),
		.upd_nib   (upd_nib),
		.upd_carry (upd_carry)
	);

	//****************************************************************
	// Access decode.
	//****************************************************************
	wire             rd_go    = SFR_RD & ~pend_ff;
	wire             wr_go    = SFR_WR & ~SFR_RD & ~pend_ff;
	wire             win1     = (SFR_ADDR == `WIN1_OFS);
	wire             indirect = (SFR_ADDR == `WIN0_OFS) | win1;
	wire [PTR_W-1:0] ptr      = win1 ? ptr1_ff : ptr0_ff;
	wire             banked   = (ptr[`REGION_MSB:`REGION_LSB] == `BANKED_REGION);
	wire             to_prog  = ptr[`PTR_PROG_BIT];
	// A pointer that lands on a window must not loop back through it.
	wire             to_self  = banked & (ptr[OFS_W-1:0] <= `WIN1_OFS);
	wire             to_core  = banked & ~to_self & (ptr[OFS_W-1:0] <= `CORE_LAST);
	// Core registers are served here even when reached through a window.
	wire [OFS_W-1:0] eff_addr = indirect ? ptr[OFS_W-1:0] : SFR_ADDR;
	wire             local_hit = ~indirect | to_self | to_core;
	wire             ext      = indirect & ~local_hit;
	wire             wr_local = wr_go & local_hit;

	//****************************************************************
	// Read multiplexer.
	//****************************************************************
	reg [DATA_W-1:0] rd_local;

	always @* begin
		rd_local = `BYTE_ZERO;
		case (eff_addr)
			`PCLO_OFS:    rd_local = PC_LOW;
			`STAT_OFS:    rd_local = {`STAT_PAD, timeout_ff, pwrdn_ff, zero_ff, nibc_ff, carry_ff};
			`PTR0_LO_OFS: rd_local = ptr0_ff[`PTR_LO_MSB:`PTR_LO_LSB];
			`PTR0_HI_OFS: rd_local = ptr0_ff[`PTR_HI_MSB:`PTR_HI_LSB];
			`PTR1_LO_OFS: rd_local = ptr1_ff[`PTR_LO_MSB:`PTR_LO_LSB];
			`PTR1_HI_OFS: rd_local = ptr1_ff[`PTR_HI_MSB:`PTR_HI_LSB];
			`BANK_OFS:    rd_local = {`BANK_PAD, bank_ff};
			`ACC_OFS:     rd_local = acc_ff;
			`PCHOLD_OFS:  rd_local = {`PCH_PAD, pch_ff};
			default:      rd_local = `BYTE_ZERO;
		endcase
	end

	//****************************************************************
	// Core registers.
	//****************************************************************
	always @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ptr0_ff <= `PTR_RST;
			ptr1_ff <= `PTR_RST;
			bank_ff <= `BANK_RST;
			acc_ff <= `BYTE_ZERO;
			pch_ff <= `PCH_RST;
		end else if (OTHER_RST) begin
			ptr0_ff <= `PTR_RST;
			ptr1_ff <= `PTR_RST;
			bank_ff <= `BANK_RST;
			acc_ff <= `BYTE_ZERO;
			pch_ff <= `PCH_RST;
		end else begin
			if (wr_local && eff_addr == `PTR0_LO_OFS)
				ptr0_ff[`PTR_LO_MSB:`PTR_LO_LSB] <= SFR_WDATA;
			if (wr_local && eff_addr == `PTR0_HI_OFS)
				ptr0_ff[`PTR_HI_MSB:`PTR_HI_LSB] <= SFR_WDATA;
			if (wr_local && eff_addr == `PTR1_LO_OFS)
				ptr1_ff[`PTR_LO_MSB:`PTR_LO_LSB] <= SFR_WDATA;
			if (wr_local && eff_addr == `PTR1_HI_OFS)
				ptr1_ff[`PTR_HI_MSB:`PTR_HI_LSB] <= SFR_WDATA;
			if (wr_local && eff_addr == `BANK_OFS)
				bank_ff <= SFR_WDATA[BANK_W-1:0]; // and
			if (wr_local && eff_addr == `PCHOLD_OFS)
				pch_ff <= SFR_WDATA[PCH_W-1:0]; // and
			// The operation result wins over a register write in the same cycle.
			if (OP_VALID && OP_TO_ACC)
				acc_ff <= alu_result;
			else if (wr_local && eff_addr == `ACC_OFS)
				acc_ff <= SFR_WDATA;
		end
	end

	//****************************************************************
	// Status flags.
	//****************************************************************
	// Flags survive every reset except power-on and brown-out.
	always @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			timeout_ff <= `PWR_FLAG_RST;
			pwrdn_ff <= `PWR_FLAG_RST;
			zero_ff <= `FLAG_RST;
			nibc_ff <= `FLAG_RST;
			carry_ff <= `FLAG_RST;
		end else begin
			if (WATCHDOG_CLEAR_OP_EXEC || SLEEP_EXEC)
				timeout_ff <= 1'b1;
			else if (WDT_TIMEOUT)
				timeout_ff <= 1'b0;
			if (WATCHDOG_CLEAR_OP_EXEC)
				pwrdn_ff <= 1'b1;
			else if (SLEEP_EXEC)
				pwrdn_ff <= 1'b0;
			if (OP_VALID && upd_zero)
				zero_ff <= alu_zero;
			else if (wr_local && eff_addr == `STAT_OFS)
				zero_ff <= SFR_WDATA[`ZERO_BIT];
			if (OP_VALID && upd_nib)
				nibc_ff <= alu_nib;
			else if (wr_local && eff_addr == `STAT_OFS)
				nibc_ff <= SFR_WDATA[`NIBC_BIT];
			if (OP_VALID && upd_carry)
				carry_ff <= alu_carry; // and
			else if (wr_local && eff_addr == `STAT_OFS)
				carry_ff <= SFR_WDATA[`CARRY_BIT];
		end
	end

	//****************************************************************
	// Window access to memory.
	//****************************************************************
	// Memory answers combinationally in the strobe cycle; a slower memory would need a stall.
	always @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			pend_ff <= 1'b0;
			prog_ff <= 1'b0;
			MEM_ADDR <= `PTR_RST;
			MEM_RD <= 1'b0;
			MEM_WR <= 1'b0;
			MEM_PROG <= 1'b0;
			MEM_WDATA <= `BYTE_ZERO;
			SFR_RDATA <= `BYTE_ZERO;
			SFR_RVALID <= 1'b0;
			SFR_BUSY <= 1'b0;
		end else begin
			MEM_RD <= 1'b0;
			MEM_WR <= 1'b0;
			SFR_RVALID <= 1'b0;
			if (OTHER_RST) begin
				pend_ff <= 1'b0;
				SFR_BUSY <= 1'b0;
			end else if (pend_ff) begin
				// Program words give only their low byte.
				SFR_RDATA <= prog_ff ? PROG_RDATA[DATA_W-1:0] : MEM_RDATA;
				SFR_RVALID <= 1'b1;
				pend_ff <= 1'b0;
				SFR_BUSY <= 1'b0;
			end else if (rd_go && ext) begin
				MEM_ADDR <= ptr;
				MEM_RD <= 1'b1;
				MEM_PROG <= to_prog;
				prog_ff <= to_prog;
				pend_ff <= 1'b1;
				SFR_BUSY <= 1'b1;
			end else if (rd_go) begin
				SFR_RDATA <= rd_local;
				SFR_RVALID <= 1'b1;
			end else if (wr_go && ext && !to_prog) begin
				// Program memory is never written through a window.
				MEM_ADDR <= ptr;
				MEM_WR <= 1'b1;
				MEM_PROG <= 1'b0;
				MEM_WDATA <= SFR_WDATA;
			end
		end
	end

	//****************************************************************
	// Operation results, addressing and views.
	//****************************************************************
	always @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			OP_RESULT <= `BYTE_ZERO;
			OP_DONE <= 1'b0;
			DATA_ADDR <= {`BANK_RST, `WIN0_OFS};
			PCL_WR <= 1'b0;
			PCL_WDATA <= `BYTE_ZERO;
			PC_HIGH_LATCH <= `PCH_RST;
			ACC_Q <= `BYTE_ZERO;
			STATUS_Q <= {`STAT_PAD, `PWR_FLAG_RST, `PWR_FLAG_RST, `FLAG_RST, `FLAG_RST, `FLAG_RST};
			PTR0_Q <= `PTR_RST;
			PTR1_Q <= `PTR_RST;
			BANK_Q <= `BANK_RST;
		end else begin
			OP_DONE <= OP_VALID;
			if (OP_VALID)
				OP_RESULT <= alu_result;
			// Bank bits sit above the instruction's offset. and
			DATA_ADDR <= {bank_ff, DIRECT_OFFSET};
			PCL_WR <= wr_local & (eff_addr == `PCLO_OFS);
			if (wr_local && eff_addr == `PCLO_OFS)
				PCL_WDATA <= SFR_WDATA;
			PC_HIGH_LATCH <= pch_ff;
			ACC_Q <= acc_ff;
			STATUS_Q <= {`STAT_PAD, timeout_ff, pwrdn_ff, zero_ff, nibc_ff, carry_ff};
			PTR0_Q <= ptr0_ff;
			PTR1_Q <= ptr1_ff;
			BANK_Q <= bank_ff;
		end
	end

endmodule

`default_nettype wire

//--- hw/core_sfr_map.vh
/*
 * Constants for the core special register block: register offsets, status bit
 * positions, reset values, operation codes and indirect pointer regions.
 * Assumes it is included by bare name from files that use these macros.
 */
`ifndef CORE_SFR_MAP_VH
`define CORE_SFR_MAP_VH

//****************************************************************
// Register offsets inside every bank.
//****************************************************************
`define WIN0_OFS      7'h00
`define WIN1_OFS      7'h01
`define PCLO_OFS      7'h02
`define STAT_OFS      7'h03
`define PTR0_LO_OFS   7'h04
`define PTR0_HI_OFS   7'h05
`define PTR1_LO_OFS   7'h06
`define PTR1_HI_OFS   7'h07
`define BANK_OFS      7'h08
`define ACC_OFS       7'h09
`define PCHOLD_OFS    7'h0A
`define CORE_LAST     7'h0A

//****************************************************************
// Status bit positions.
//****************************************************************
`define TIMEOUT_BIT   4
`define PWRDN_BIT     3
`define ZERO_BIT      2
`define NIBC_BIT      1
`define CARRY_BIT     0
`define NIB_MSB       3

//****************************************************************
// Reset values.
//****************************************************************
`define BYTE_ZERO     8'h00
`define PTR_RST       16'h0000
`define BANK_RST      6'h00
`define PCH_RST       7'h00
`define FLAG_RST      1'b0
`define PWR_FLAG_RST  1'b1
`define STAT_PAD      3'h0
`define BANK_PAD      2'h0
`define PCH_PAD       1'b0

//****************************************************************
// Indirect pointer regions.
//****************************************************************
`define PTR_PROG_BIT  15
`define REGION_MSB    15
`define REGION_LSB    13
`define BANKED_REGION 3'h0
`define PTR_LO_MSB    7
`define PTR_LO_LSB    0
`define PTR_HI_MSB    15
`define PTR_HI_LSB    8

//****************************************************************
// Operation codes.
//****************************************************************
`define OP_ADD_FILE   4'h0
`define OP_ADD_LIT    4'h1
`define OP_SUB_LIT    4'h2
`define OP_SUB_FILE   4'h3
`define OP_ROT_RIGHT  4'h4
`define OP_ROT_LEFT   4'h5
`define OP_AND        4'h6
`define OP_IOR        4'h7
`define OP_XOR        4'h8

`endif

//--- hw/core_alu_flags.v
/*
 * Combinational arithmetic and logic unit with status flag generation.
 * Assumes the caller registers the result and applies only the flags whose
 * update strobes are high.
 */
`timescale 1ns/100ps
`default_nettype none
`include "core_sfr_map.vh"

module core_alu_flags #(
	parameter W = 8
) (
	input  wire [3:0]   op,
	input  wire [W-1:0] acc,
	input  wire [W-1:0] opnd,
	input  wire         carry_in,
	output reg  [W-1:0] result,
	output reg          zero,
	output reg          nib_carry,
	output reg          carry,
	output reg          upd_zero,
	output reg          upd_nib,
	output reg          upd_carry
);

	reg [W:0]   sum;
	reg [4:0]   nib;
	reg [W-1:0] addend;
	reg         cin;

	always @* begin
		addend = acc;
		cin = 1'b0;
		// Subtraction adds the inverted accumulator plus one, so carry means no borrow.
		if (op == `OP_SUB_LIT || op == `OP_SUB_FILE) begin
			addend = ~acc;
			cin = 1'b1;
		end
		sum = {1'b0, opnd} + {1'b0, addend} + {{W{1'b0}}, cin};
		nib = {1'b0, opnd[`NIB_MSB:0]} + {1'b0, addend[`NIB_MSB:0]} + {4'h0, cin};
		result = sum[W-1:0];
		nib_carry = nib[`NIB_MSB+1];
		carry = sum[W];
		upd_zero = 1'b1;
		upd_nib = 1'b1;
		upd_carry = 1'b1;
		case (op)
			`OP_ADD_FILE, `OP_ADD_LIT, `OP_SUB_LIT, `OP_SUB_FILE: begin
				upd_nib = 1'b1;
			end
			`OP_ROT_RIGHT: begin
				result = {carry_in, opnd[W-1:1]};
				carry = opnd[0];
				upd_zero = 1'b0;
				upd_nib = 1'b0;
			end
			`OP_ROT_LEFT: begin
				result = {opnd[W-2:0], carry_in};
				carry = opnd[W-1];
				upd_zero = 1'b0;
				upd_nib = 1'b0;
			end
			`OP_AND: begin
				result = opnd & acc;
				upd_nib = 1'b0;
				upd_carry = 1'b0;
			end
			`OP_IOR: begin
				result = opnd | acc;
				upd_nib = 1'b0;
				upd_carry = 1'b0;
			end
			`OP_XOR: begin
				result = opnd ^ acc;
				upd_nib = 1'b0;
				upd_carry = 1'b0;
			end
			default: begin
				result = opnd;
				upd_zero = 1'b0;
				upd_nib = 1'b0;
				upd_carry = 1'b0;
			end
		endcase
		zero = (result == {W{1'b0}});
	end

endmodule

`default_nettype wire

//--- dv/core_sfr_assertions.sv
/* Concurrent checks on the ports of the core special register block.
   Assumes it is bound to core_sfr built with its default widths. */
`timescale 1ns/100ps
`default_nettype none
module core_sfr_assertions (
	// Clock and reset.
	input wire logic        SYS_CLK,
	input wire logic        RST_N,
	// Register and memory side.
	input wire logic        SFR_BUSY,
	input wire logic [7:0]  SFR_RDATA,
	input wire logic        SFR_RVALID,
	input wire logic [15:0] MEM_ADDR,
	input wire logic        MEM_RD,
	input wire logic        MEM_WR,
	input wire logic        MEM_PROG,
	input wire logic [7:0]  MEM_RDATA,
	input wire logic [13:0] PROG_RDATA,
	// Operations, events and views.
	input wire logic        OP_VALID,
	input wire logic [3:0]  OP_CODE,
	input wire logic [7:0]  OP_OPERAND,
	input wire logic [7:0]  OP_RESULT,
	input wire logic        SLEEP_EXEC,
	input wire logic        WATCHDOG_CLEAR_OP_EXEC,
	input wire logic [6:0]  DIRECT_OFFSET,
	input wire logic [12:0] DATA_ADDR,
	input wire logic [7:0]  STATUS_Q,
	input wire logic [5:0]  BANK_Q
);
	//**********
	// Properties.
	//**********
	default clocking dflt @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	sequence s_mem_read; MEM_RD && SFR_BUSY; endsequence
	sequence s_read_done; SFR_RVALID && !SFR_BUSY; endsequence
	property p_win_read; s_mem_read |=> s_read_done; endproperty
	a_win_read: assert property (p_win_read) else $error("window read late");
	property p_mem_data; MEM_RD && !MEM_PROG |=> SFR_RDATA == $past(MEM_RDATA); endproperty
	a_mem_data: assert property (p_mem_data) else $error("window data wrong");
	property p_prog_data; MEM_RD && MEM_PROG |=> SFR_RDATA == $past(PROG_RDATA[7:0]); endproperty
	a_prog_data: assert property (p_prog_data)
		else $error("program byte wrong");
	// Local registers and the windows themselves must never leak onto the memory side.
	property p_mem_region;
		(MEM_RD || MEM_WR) |-> !(MEM_ADDR[15:13] == 3'h0 && MEM_ADDR[6:0] <= 7'h0A)
			&& !(MEM_WR && MEM_ADDR[15]);
	endproperty
	a_mem_region: assert property (p_mem_region)
		else $error("bad memory access");
	property p_zero;
		OP_VALID && OP_CODE < 4'h9 && OP_CODE[3:1] != 3'h2
			|=> ##1 STATUS_Q[2] == ($past(OP_RESULT) == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	property p_rot_right; OP_VALID && OP_CODE == 4'h4 |=> ##1 STATUS_Q[0] == $past(OP_OPERAND[0], 2);
	endproperty
	a_rot_right: assert property (p_rot_right)
		else $error("rotate carry wrong");
	property p_sleep; SLEEP_EXEC && !WATCHDOG_CLEAR_OP_EXEC |=> ##1 !STATUS_Q[3]; endproperty
	a_sleep: assert property (p_sleep) else $error("power flag kept");
	property p_watchdog_clear_op; WATCHDOG_CLEAR_OP_EXEC |=> ##1 STATUS_Q[3]; endproperty
	a_watchdog_clear_op: assert property (p_watchdog_clear_op) else $error("power flag not set");
	property p_por; $rose(RST_N) |-> STATUS_Q == 8'h18; endproperty
	a_por: assert property (p_por) else $error("status after reset");
	property p_data_addr; $past(RST_N) |-> DATA_ADDR == {BANK_Q, $past(DIRECT_OFFSET)}; endproperty
	a_data_addr: assert property (p_data_addr)
		else $error("direct address wrong");
endmodule
`default_nettype wire

//--- dv/core_sfr_mem_model.sv
/* Behavioural data and program memory behind the indirect windows.
   Assumes MEM_RD and MEM_WR are one-cycle strobes from the block. */
`timescale 1ns/100ps
`default_nettype none
module core_sfr_mem_model (
	// Clock.
	input  wire logic        clk,
	// Memory port.
	input  wire logic [15:0] addr,
	input  wire logic        rd,
	input  wire logic        wr,
	input  wire logic [7:0]  wdata,
	output var  logic [7:0]  rdata,
	output var  logic [13:0] prog_rdata
);
	//**********
	// Storage.
	//**********
	logic [7:0] ram [0:255];
	logic [7:0] last = 8'h5A;
	always @(posedge clk) begin
		if (wr)
			ram[addr[7:0]] <= wdata;
		last <= ~last;
	end
	// Outside a read the lines toggle, so stale data can never pass as an answer.
	always_comb rdata = rd ? ram[addr[7:0]] : last;
	always_comb prog_rdata = rd ? {6'h2A, addr[7:0] ^ 8'hC3} : {6'h15, last};
endmodule
`default_nettype wire

//--- dv/cpu_core_special_registers_test.sv
/* Self-checking bench for the core special register block.
   Assumes the memory model answers window reads in the strobe cycle. */
`timescale 1ns/100ps
`default_nettype none
`include "core_sfr_map.vh"
module cpu_core_special_registers_test;
	logic        RST_N = 1'b0, OTHER_RST = 1'b0, SFR_RD = 1'b0, SFR_WR = 1'b0, OP_VALID = 1'b0;
	logic        OP_TO_ACC = 1'b0, SLEEP_EXEC = 1'b0, WATCHDOG_CLEAR_OP_EXEC = 1'b0, WDT_TIMEOUT = 1'b0;
	logic [3:0]  OP_CODE = 4'h0;
	logic [6:0]  SFR_ADDR = 7'h00, DIRECT_OFFSET = 7'h00, PC_HIGH_LATCH;
	logic [7:0]  SFR_WDATA = 8'h00, OP_OPERAND = 8'h00, PC_LOW = 8'h5A, res;
	logic        SYS_CLK, SFR_RVALID, SFR_BUSY, MEM_RD, MEM_WR, MEM_PROG, OP_DONE, PCL_WR, done;
	logic [5:0]  BANK_Q;
	logic [7:0]  SFR_RDATA, MEM_WDATA, MEM_RDATA, OP_RESULT, PCL_WDATA, ACC_Q, STATUS_Q;
	logic [12:0] DATA_ADDR;
	logic [13:0] PROG_RDATA;
	logic [15:0] MEM_ADDR, PTR0_Q, PTR1_Q;
	int          checks = 0;
	int          fail_count = 0;
	core_sfr uut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .OTHER_RST(OTHER_RST), .SFR_ADDR(SFR_ADDR),
		.SFR_RD(SFR_RD), .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
		.SFR_RVALID(SFR_RVALID), .SFR_BUSY(SFR_BUSY), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD),
		.MEM_WR(MEM_WR), .MEM_PROG(MEM_PROG), .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA),
		.PROG_RDATA(PROG_RDATA), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE), .OP_OPERAND(OP_OPERAND),
		.OP_TO_ACC(OP_TO_ACC), .OP_RESULT(OP_RESULT), .OP_DONE(OP_DONE), .SLEEP_EXEC(SLEEP_EXEC),
		.WATCHDOG_CLEAR_OP_EXEC(WATCHDOG_CLEAR_OP_EXEC), .WDT_TIMEOUT(WDT_TIMEOUT), .DIRECT_OFFSET(DIRECT_OFFSET),
		.DATA_ADDR(DATA_ADDR), .PC_LOW(PC_LOW), .PCL_WR(PCL_WR), .PCL_WDATA(PCL_WDATA),
		.PC_HIGH_LATCH(PC_HIGH_LATCH), .ACC_Q(ACC_Q), .STATUS_Q(STATUS_Q), .PTR0_Q(PTR0_Q),
		.PTR1_Q(PTR1_Q), .BANK_Q(BANK_Q));
	core_sfr_mem_model mem (.clk(SYS_CLK), .addr(MEM_ADDR), .rd(MEM_RD), .wr(MEM_WR),
		.wdata(MEM_WDATA), .rdata(MEM_RDATA), .prog_rdata(PROG_RDATA));
	//**********
	// Helpers.
	//**********
	task automatic tick();
		@(posedge SYS_CLK);
		#1;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		tick();
		SFR_ADDR = a;
		SFR_WDATA = v;
		SFR_WR = 1'b1;
		tick();
		SFR_WR = 1'b0;
	endtask
	task automatic rdc(input logic [6:0] a, input logic [7:0] e);
		int n;
		tick();
		SFR_ADDR = a;
		SFR_RD = 1'b1;
		tick();
		SFR_RD = 1'b0;
		n = 0;
		while (SFR_RVALID !== 1'b1 && n < 3) begin
			tick();
			n++;
		end
		chk({SFR_RVALID, SFR_RDATA}, {1'b1, e});
	endtask
	task automatic op(input logic [3:0] c, input logic [7:0] v, input logic t);
		tick();
		OP_CODE = c;
		OP_OPERAND = v;
		OP_TO_ACC = t;
		OP_VALID = 1'b1;
		tick();
		OP_VALID = 1'b0;
		res = OP_RESULT;
		done = OP_DONE;
		tick();
	endtask
	task automatic ev(input logic [2:0] e);
		tick();
		{SLEEP_EXEC, WATCHDOG_CLEAR_OP_EXEC, WDT_TIMEOUT} = e;
		tick();
		{SLEEP_EXEC, WATCHDOG_CLEAR_OP_EXEC, WDT_TIMEOUT} = 3'h0;
		tick();
	endtask
	// Subtraction adds the inverted accumulator plus one, so carry reads as no-borrow.
	function automatic logic [10:0] alu(input logic [3:0] c, input logic [7:0] a, input logic [7:0] v);
		logic [7:0] b;
		logic [8:0] s;
		logic [4:0] h;
		b = c[1] ? ~a : a;
		s = {1'b0, v} + {1'b0, b} + {8'h00, c[1]};
		h = {1'b0, v[3:0]} + {1'b0, b[3:0]} + {4'h0, c[1]};
		return {s[7:0], s[7:0] == 8'h00, h[4], s[8]};
	endfunction
	//**********
	// Scenarios.
	//**********
	task automatic t_regs();
		chk(STATUS_Q, 8'h18);
		rdc(`PCLO_OFS, PC_LOW);
		for (int a = 4; a <= 10; a++) rdc(a[6:0], 8'h00);
		for (int a = 4; a <= 10; a++) wr(a[6:0], 8'hC0 + a[7:0]);
		wr(7'h7F, 8'hFF);
		rdc(`PTR0_HI_OFS, 8'hC5);
		rdc(`PTR1_LO_OFS, 8'hC6);
		rdc(`BANK_OFS, 8'h08);
		rdc(`ACC_OFS, 8'hC9);
		rdc(`PCHOLD_OFS, 8'h4A);
		rdc(7'h7F, 8'h00);
		// A write that comes with a read in the same cycle is refused.
		tick();
		{SFR_ADDR, SFR_WDATA, SFR_RD, SFR_WR} = {`ACC_OFS, 8'h77, 2'b11};
		tick();
		{SFR_RD, SFR_WR} = 2'b00;
		chk({SFR_RVALID, SFR_RDATA}, {1'b1, 8'hC9});
		rdc(`ACC_OFS, 8'hC9);
		chk({PTR0_Q, PTR1_Q}, {16'hC5C4, 16'hC7C6});
		chk({BANK_Q, PC_HIGH_LATCH}, {6'h08, 7'h4A});
		wr(`PCLO_OFS, 8'h33);
		chk({PCL_WR, PCL_WDATA}, 9'h133);
		DIRECT_OFFSET = 7'h12;
		wr(`BANK_OFS, 8'h05);
		tick();
		chk(DATA_ADDR, {6'h05, 7'h12});
	endtask
	task automatic t_arith();
		logic [7:0] av [3] = '{8'h0F, 8'hFF, 8'h01};
		logic [7:0] vv [3] = '{8'h01, 8'h01, 8'h10};
		logic [10:0] e;
		for (int c = 0; c < 4; c++) begin
			for (int i = 0; i < 3; i++) begin
				wr(`ACC_OFS, av[i]);
				op(c[3:0], vv[i], 1'b0);
				e = alu(c[3:0], av[i], vv[i]);
				chk({done, res, STATUS_Q[2:0]}, {1'b1, e});
			end
		end
		op(`OP_ROT_RIGHT, 8'h02, 1'b0);
		chk({res, STATUS_Q[2:0]}, {8'h81, 3'b000});
		op(`OP_ROT_LEFT, 8'h80, 1'b0);
		chk({res, STATUS_Q[2:0]}, {8'h00, 3'b001});
		op(`OP_XOR, 8'h01, 1'b1);
		chk({res, STATUS_Q[2:0]}, {8'h00, 3'b101});
		rdc(`ACC_OFS, 8'h00);
		op(`OP_ADD_LIT, 8'h7E, 1'b1);
		chk(ACC_Q, 8'h7E);
		op(`OP_AND, 8'h81, 1'b0);
		chk({res, STATUS_Q[2:0]}, {8'h00, 3'b100});
		op(`OP_IOR, 8'h80, 1'b0);
		chk({res, STATUS_Q[2:0]}, {8'hFE, 3'b000});
		// An undecoded code passes the operand and leaves every flag alone.
		op(4'hF, 8'h00, 1'b0);
		chk({res, STATUS_Q[2:0]}, {8'h00, 3'b000});
	endtask
	task automatic t_power();
		ev(3'b100);
		chk(STATUS_Q[4:3], 2'b10);
		ev(3'b001);
		chk(STATUS_Q[4:3], 2'b00);
		ev(3'b010);
		chk(STATUS_Q[4:3], 2'b11);
		ev(3'b101);
		chk(STATUS_Q[4:3], 2'b10);
		ev(3'b111);
		chk(STATUS_Q[4:3], 2'b11);
		op(`OP_SUB_LIT, 8'hFF, 1'b0);
		chk(STATUS_Q, 8'h1B);
		tick();
		OTHER_RST = 1'b1;
		tick();
		OTHER_RST = 1'b0;
		tick();
		chk({PTR0_Q, BANK_Q, STATUS_Q}, {16'h0000, 6'h00, 8'h1B});
		chk(ACC_Q, 8'h00);
		RST_N = 1'b0;
		tick();
		chk({STATUS_Q, ACC_Q}, {8'h18, 8'h00});
		RST_N = 1'b1;
	endtask
	task automatic t_window();
		wr(`PTR0_LO_OFS, 8'h20);
		wr(`WIN0_OFS, 8'h3C);
		rdc(`WIN0_OFS, 8'h3C);
		wr(`PTR1_LO_OFS, 8'h05);
		wr(`PTR1_HI_OFS, 8'h80);
		rdc(`WIN1_OFS, 8'hC6);
		wr(`WIN1_OFS, 8'h11);
		wr(`PTR0_LO_OFS, 8'h01);
		wr(`WIN0_OFS, 8'h55);
		rdc(`WIN0_OFS, 8'h00);
		wr(`PTR0_LO_OFS, 8'h09);
		wr(`WIN0_OFS, 8'h6B);
		rdc(`ACC_OFS, 8'h6B);
		rdc(`WIN0_OFS, 8'h6B);
	endtask
	task automatic results();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		SYS_CLK = 1'b0;
		forever #25 SYS_CLK = ~SYS_CLK;
	end
	initial begin
		#100000;
		fail_count++;
		results();
	end
	initial begin
		repeat (5) @(posedge SYS_CLK);
		#1;
		RST_N = 1'b1;
		t_regs();
		t_arith();
		t_power();
		t_window();
		results();
	end
endmodule
bind core_sfr core_sfr_assertions chk_i (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .SFR_BUSY(SFR_BUSY),
	.SFR_RDATA(SFR_RDATA), .SFR_RVALID(SFR_RVALID), .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD),
	.MEM_WR(MEM_WR), .MEM_PROG(MEM_PROG), .MEM_RDATA(MEM_RDATA), .PROG_RDATA(PROG_RDATA),
	.OP_VALID(OP_VALID), .OP_CODE(OP_CODE), .OP_OPERAND(OP_OPERAND), .OP_RESULT(OP_RESULT),
	.SLEEP_EXEC(SLEEP_EXEC), .WATCHDOG_CLEAR_OP_EXEC(WATCHDOG_CLEAR_OP_EXEC), .DIRECT_OFFSET(DIRECT_OFFSET),
	.DATA_ADDR(DATA_ADDR), .STATUS_Q(STATUS_Q), .BANK_Q(BANK_Q));
`default_nettype wire
